// >>> hw/dma_status_irq_pointer_regs.sv
// register bank: pair-a status and irq mask, base shadows, sdram copy, channel three/four pointers
`timescale 1ns/1ps

module dma_status_irq_pointer_regs #(
  parameter int PTR_W = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register access from pci host or embedded processor
  input wire dma_regs_pkg::reg_req_t reg_req,
  input wire logic protected_mode,
  output logic rd_valid_q,
  output logic [31:0] rd_data_q,
  // status events from the channel engines and processor bridge
  input wire dma_regs_pkg::evt_t evt,
  input wire logic [1:0] dst_abort_evt,
  input wire logic [1:0] dst_done_evt,
  input wire logic [1:0] dst_last_evt,
  input wire logic [1:0] dst_wait_evt,
  input wire logic [1:0] dst_overflow_evt,
  // interrupt routing from the processor configuration register
  input wire logic route_to_pci,
  input wire logic route_to_proc,
  output logic irq_pci_q,
  output logic irq_proc_q,
  // pci base address registers and eeprom words
  input wire logic [31:0] base_window0,
  input wire logic [31:0] base_window1,
  input wire logic [31:0] base_window2,
  input wire logic eeprom_words_valid,
  input wire logic [15:0] eeprom_word_10,
  input wire logic [15:0] eeprom_word_11,
  // channel three and four engine interface
  input wire logic chan3_enable,
  input wire logic chan4_enable,
  input wire dma_regs_pkg::dst_step_t chan3_dst_step,
  input wire dma_regs_pkg::dst_step_t chan4_dst_step,
  output logic [31:0] chan3_src_ptr_q,
  output logic [31:0] chan4_src_ptr_q,
  output logic [31:0] chan3_dst_ptr_q,
  output logic [31:0] chan4_dst_ptr_q
);

  // the bus data path and pointers are a fixed 32 bits wide
  if (PTR_W != 32) begin : g_ptr_w_check
    $error("PTR_W must be 32");
  end

  // the eeprom fields and their forced-one bits must tile the 32-bit copy exactly
  if (dma_regs_pkg::SDRAM_LO_FORCE_BIT != dma_regs_pkg::SDRAM_FIELD_W ||
      dma_regs_pkg::SDRAM_HI_FORCE_BIT != 2 * dma_regs_pkg::SDRAM_FIELD_W + 1) begin : g_sdram_check
    $error("sdram copy fields do not tile the word");
  end

  // destination flags are written five at a time, from the abort bit down to overflow
  if (dma_regs_pkg::BIT_CH2_DST_ABORT - dma_regs_pkg::BIT_CH2_DST_OVERFLOW != 4 ||
      dma_regs_pkg::BIT_CH1_DST_ABORT - dma_regs_pkg::BIT_CH1_DST_OVERFLOW != 4) begin : g_dst_flag_check
    $error("destination flag groups are not five contiguous bits");
  end

  // a skip passes whole commands, so it must be a multiple of the plain step and larger
  if (dma_regs_pkg::DST_SKIP_STEP % dma_regs_pkg::DST_CMD_STEP != 0 ||
      dma_regs_pkg::DST_SKIP_STEP <= dma_regs_pkg::DST_CMD_STEP) begin : g_skip_check
    $error("skip advance is not a whole number of commands");
  end

  // next destination pointer: jump wins over skip, skip over the plain step
  function automatic logic [31:0] next_dst_ptr(input logic [31:0] cur, input dma_regs_pkg::dst_step_t st);
    logic [31:0] nxt;
    nxt = cur + dma_regs_pkg::DST_CMD_STEP;
    if (st.jump) begin
      nxt = st.target;
    end else if (st.skip) begin
      nxt = cur + dma_regs_pkg::DST_SKIP_STEP;
    end
    return nxt;
  endfunction

  // pci is locked out of this offset while protected mode is on
  function automatic logic pci_locked(input logic [7:0] ofs);
    logic hit;
    hit = 1'b0;
    case (ofs)
      dma_regs_pkg::OFS_PAIR_A_STATUS,
      dma_regs_pkg::OFS_PAIR_A_MASK,
      dma_regs_pkg::OFS_SDRAM_COPY,
      dma_regs_pkg::OFS_CH3_SRC_PTR,
      dma_regs_pkg::OFS_CH4_SRC_PTR,
      dma_regs_pkg::OFS_CH3_DST_PTR: hit = 1'b1;
      default: hit = 1'b0; // base shadows and ch4 dest stay open
    endcase
    return hit;
  endfunction

  // write strobe for one register; the enable already excludes refused pci writes
  function automatic logic wr_hit(input logic en, input logic [7:0] ofs, input logic [7:0] target);
    return en && ofs == target;
  endfunction

  // destination pointer next value: a software write wins over a same-cycle advance,
  // and a disabled channel ignores its engine's step reports
  function automatic logic [31:0] dst_ptr_next(input logic [31:0] cur, input logic wr, input logic [31:0] wdata,
    input logic en, input dma_regs_pkg::dst_step_t st);
    logic [31:0] nxt;
    nxt = cur;
    if (wr) begin
      nxt = wdata; // no alignment mask
    end else if (en && st.done) begin
      nxt = next_dst_ptr(cur, st);
    end
    return nxt;
  endfunction

  logic [31:0] status_q;
  logic [31:0] mask_q;
  logic [31:0] win0_q;
  logic [31:0] win1_q;
  logic [31:0] win2_q;
  logic [31:0] sdram_q;
  logic sdram_pending_q;
  logic acc_ok;
  logic wr_en;
  logic rd_en;
  logic [31:0] evt_vec;
  logic [31:0] clr_vec;
  logic [31:0] status_d;
  logic [31:0] rd_data_d;
  logic wr_status;
  logic wr_mask;
  logic wr_src3;
  logic wr_src4;
  logic wr_dst3;
  logic wr_dst4;
  logic irq_any;
  logic [31:0] chan3_dst_ptr_d;
  logic [31:0] chan4_dst_ptr_d;

  // an access is honoured unless pci hits a locked register in protected mode
  assign acc_ok = !(reg_req.from_pci && protected_mode && pci_locked(reg_req.offset));
  assign wr_en = reg_req.valid && reg_req.write && acc_ok;
  assign rd_en = reg_req.valid && !reg_req.write;

  // per-register write strobes
  assign wr_status = wr_hit(wr_en, reg_req.offset, dma_regs_pkg::OFS_PAIR_A_STATUS);
  assign wr_mask = wr_hit(wr_en, reg_req.offset, dma_regs_pkg::OFS_PAIR_A_MASK);
  assign wr_src3 = wr_hit(wr_en, reg_req.offset, dma_regs_pkg::OFS_CH3_SRC_PTR);
  assign wr_src4 = wr_hit(wr_en, reg_req.offset, dma_regs_pkg::OFS_CH4_SRC_PTR);
  assign wr_dst3 = wr_hit(wr_en, reg_req.offset, dma_regs_pkg::OFS_CH3_DST_PTR);
  assign wr_dst4 = wr_hit(wr_en, reg_req.offset, dma_regs_pkg::OFS_CH4_DST_PTR);

  // next destination pointers, one set of rules for both channels
  assign chan3_dst_ptr_d = dst_ptr_next(chan3_dst_ptr_q, wr_dst3, reg_req.wdata, chan3_enable, chan3_dst_step);
  assign chan4_dst_ptr_d = dst_ptr_next(chan4_dst_ptr_q, wr_dst4, reg_req.wdata, chan4_enable, chan4_dst_step);

  // any enabled status flag; the interrupt is a level, not a pulse
  assign irq_any = |(status_q & mask_q);

  // gather hardware events into the status bit layout
  always_comb begin
    evt_vec = 32'h0000_0000;
    evt_vec[dma_regs_pkg::BIT_CH2_SRC_ABORT] = evt.src_abort[1];
    evt_vec[dma_regs_pkg::BIT_CH1_SRC_ABORT] = evt.src_abort[0];
    evt_vec[dma_regs_pkg::BIT_CH2_SRC_DONE] = evt.src_done[1];
    evt_vec[dma_regs_pkg::BIT_CH1_SRC_DONE] = evt.src_done[0];
    evt_vec[dma_regs_pkg::BIT_CH2_SRC_LAST] = evt.src_last[1];
    evt_vec[dma_regs_pkg::BIT_CH1_SRC_LAST] = evt.src_last[0];
    evt_vec[dma_regs_pkg::BIT_CH2_SRC_WAIT] = evt.src_wait[1];
    evt_vec[dma_regs_pkg::BIT_CH1_SRC_WAIT] = evt.src_wait[0];
    evt_vec[dma_regs_pkg::BIT_PROC_WR_ERR] = evt.proc_wr_err;
    evt_vec[dma_regs_pkg::BIT_PROC_RD_ERR] = evt.proc_rd_err;
    // destination flags: abort, done, last, waiting, overflow per channel
    evt_vec[dma_regs_pkg::BIT_CH2_DST_ABORT -: 5] =
      {dst_abort_evt[1], dst_done_evt[1], dst_last_evt[1], dst_wait_evt[1], dst_overflow_evt[1]};
    evt_vec[dma_regs_pkg::BIT_CH1_DST_ABORT -: 5] =
      {dst_abort_evt[0], dst_done_evt[0], dst_last_evt[0], dst_wait_evt[0], dst_overflow_evt[0]};
  end

  // write-one-to-clear; an event in the clearing cycle still sets the flag
  always_comb begin
    clr_vec = 32'h0000_0000;
    if (wr_status) begin
      clr_vec = reg_req.wdata; // zeros leave bits alone
    end
    status_d = ((status_q & ~clr_vec) | evt_vec) & dma_regs_pkg::STATUS_IMPL_MASK;
  end

  // sticky status flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= dma_regs_pkg::RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // interrupt mask, same layout as status; reserved bits kept at zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= dma_regs_pkg::RST_MASK;
    end else if (wr_mask) begin
      mask_q <= reg_req.wdata & dma_regs_pkg::STATUS_IMPL_MASK;
    end
  end

  // pci interrupt; a level while any enabled flag stands, one cycle behind the flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_pci_q <= 1'b0;
    end else begin
      irq_pci_q <= route_to_pci && irq_any;
    end
  end

  // processor interrupt, routed independently of the pci one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_proc_q <= 1'b0;
    end else begin
      irq_proc_q <= route_to_proc && irq_any;
    end
  end

  // base window zero shadow; contents before the first edge are undefined, so no reset
  always_ff @(posedge clk_sys) begin
    win0_q <= base_window0;
  end

  // base window one shadow
  always_ff @(posedge clk_sys) begin
    win1_q <= base_window1;
  end

  // base window two shadow
  always_ff @(posedge clk_sys) begin
    win2_q <= base_window2;
  end

  // catch the eeprom timing words once after reset; pending is a reset constant, not a port value
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sdram_pending_q <= 1'b1;
    end else if (sdram_pending_q && eeprom_words_valid) begin
      sdram_pending_q <= 1'b0;
    end
  end

  // sdram copy; no software write path, it is read-only
  always_ff @(posedge clk_sys) begin
    if (sdram_pending_q && eeprom_words_valid) begin
      sdram_q[dma_regs_pkg::SDRAM_HI_FORCE_BIT] <= 1'b1;
      sdram_q[dma_regs_pkg::SDRAM_HI_FORCE_BIT-1 -: dma_regs_pkg::SDRAM_FIELD_W] <=
        eeprom_word_11[dma_regs_pkg::SDRAM_FIELD_W-1:0];
      sdram_q[dma_regs_pkg::SDRAM_LO_FORCE_BIT] <= 1'b1;
      sdram_q[dma_regs_pkg::SDRAM_FIELD_W-1:0] <= eeprom_word_10[dma_regs_pkg::SDRAM_FIELD_W-1:0];
    end
  end

  // channel three source list pointer, full byte address with no alignment mask
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chan3_src_ptr_q <= dma_regs_pkg::RST_PTR;
    end else if (wr_src3) begin
      chan3_src_ptr_q <= reg_req.wdata;
    end
  end

  // channel four source list pointer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chan4_src_ptr_q <= dma_regs_pkg::RST_PTR;
    end else if (wr_src4) begin
      chan4_src_ptr_q <= reg_req.wdata;
    end
  end

  // channel three destination pointer; software is expected to write it only while disabled
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chan3_dst_ptr_q <= dma_regs_pkg::RST_PTR;
    end else begin
      chan3_dst_ptr_q <= chan3_dst_ptr_d;
    end
  end

  // channel four destination pointer, same handling
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chan4_dst_ptr_q <= dma_regs_pkg::RST_PTR;
    end else begin
      chan4_dst_ptr_q <= chan4_dst_ptr_d;
    end
  end

  // read mux; locked or unmapped offsets read zero
  always_comb begin
    rd_data_d = 32'h0000_0000;
    if (acc_ok) begin
      case (reg_req.offset)
        dma_regs_pkg::OFS_PAIR_A_STATUS: rd_data_d = status_q;
        dma_regs_pkg::OFS_PAIR_A_MASK: rd_data_d = mask_q;
        dma_regs_pkg::OFS_BASE_WIN0: rd_data_d = win0_q;
        dma_regs_pkg::OFS_BASE_WIN1: rd_data_d = win1_q;
        dma_regs_pkg::OFS_BASE_WIN2: rd_data_d = win2_q;
        dma_regs_pkg::OFS_SDRAM_COPY: rd_data_d = sdram_q;
        dma_regs_pkg::OFS_CH3_SRC_PTR: rd_data_d = chan3_src_ptr_q;
        dma_regs_pkg::OFS_CH4_SRC_PTR: rd_data_d = chan4_src_ptr_q;
        dma_regs_pkg::OFS_CH3_DST_PTR: rd_data_d = chan3_dst_ptr_q;
        dma_regs_pkg::OFS_CH4_DST_PTR: rd_data_d = chan4_dst_ptr_q;
        default: rd_data_d = 32'h0000_0000;
      endcase
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 32'h0000_0000;
    end else begin
      rd_valid_q <= rd_en;
      rd_data_q <= rd_en ? rd_data_d : 32'h0000_0000;
    end
  end

endmodule

// >>> common/dma_regs_pkg.sv
// constants and carrier types for the dma status, irq and pointer register bank
package dma_regs_pkg;

  // register offsets within the register window
  localparam logic [7:0] OFS_PAIR_A_STATUS = 8'hb8;
  localparam logic [7:0] OFS_PAIR_A_MASK = 8'hbc;
  localparam logic [7:0] OFS_BASE_WIN0 = 8'hc0;
  localparam logic [7:0] OFS_BASE_WIN1 = 8'hc4;
  localparam logic [7:0] OFS_BASE_WIN2 = 8'hc8;
  localparam logic [7:0] OFS_SDRAM_COPY = 8'hcc;
  localparam logic [7:0] OFS_CH3_SRC_PTR = 8'hd0;
  localparam logic [7:0] OFS_CH4_SRC_PTR = 8'hd4;
  localparam logic [7:0] OFS_CH3_DST_PTR = 8'hd8;
  localparam logic [7:0] OFS_CH4_DST_PTR = 8'hdc;

  // status and mask bit positions
  localparam int BIT_CH2_DST_ABORT = 29;
  localparam int BIT_CH2_DST_OVERFLOW = 25;
  localparam int BIT_CH1_DST_ABORT = 21;
  localparam int BIT_CH1_DST_OVERFLOW = 17;
  localparam int BIT_CH2_SRC_ABORT = 13;
  localparam int BIT_CH2_SRC_DONE = 12;
  localparam int BIT_CH2_SRC_LAST = 11;
  localparam int BIT_CH2_SRC_WAIT = 10;
  localparam int BIT_CH1_SRC_ABORT = 5;
  localparam int BIT_CH1_SRC_DONE = 4;
  localparam int BIT_CH1_SRC_LAST = 3;
  localparam int BIT_CH1_SRC_WAIT = 2;
  localparam int BIT_PROC_WR_ERR = 1;
  localparam int BIT_PROC_RD_ERR = 0;

  // implemented status bits; 31:30, 24:22, 16:14 and 9:6 are reserved
  localparam logic [31:0] STATUS_IMPL_MASK = 32'h3e3e_3c3f;

  // reset values
  localparam logic [31:0] RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_PTR = 32'h0000_0000;

  // sdram copy: eeprom word fields and forced-one bits
  localparam int SDRAM_FIELD_W = 15;
  localparam int SDRAM_HI_FORCE_BIT = 31;
  localparam int SDRAM_LO_FORCE_BIT = 15;

  // destination command advance amounts in bytes
  localparam logic [31:0] DST_CMD_STEP = 32'h0000_0010;
  localparam logic [31:0] DST_SKIP_STEP = 32'h0000_0020;

  // register access request from the pci host or the embedded processor
  typedef struct packed {
    logic valid;
    logic write;
    logic from_pci;
    logic [7:0] offset;
    logic [31:0] wdata;
  } reg_req_t;

  // per-channel destination command completion report
  typedef struct packed {
    logic done;
    logic jump;
    logic skip;
    logic [31:0] target;
  } dst_step_t;

  // source side and processor event pulses
  typedef struct packed {
    logic [1:0] src_abort;
    logic [1:0] src_done;
    logic [1:0] src_last;
    logic [1:0] src_wait;
    logic [1:0] dst_event_unused;
    logic proc_wr_err;
    logic proc_rd_err;
  } evt_t;

endpackage

// >>> dv/dma_regs_checker.sv
// assertion checker for the dma status, irq and pointer register bank
`timescale 1ns/1ps
module dma_regs_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire dma_regs_pkg::reg_req_t reg_req,
  input wire logic protected_mode,
  input wire logic rd_valid_q,
  input wire logic [31:0] rd_data_q,
  // irq and shadow
  input wire logic route_to_pci,
  input wire logic irq_pci_q,
  input wire logic [31:0] base_window0,
  // channel pointers
  input wire logic chan3_enable,
  input wire dma_regs_pkg::dst_step_t chan3_dst_step,
  input wire logic [31:0] chan3_src_ptr_q,
  input wire logic [31:0] chan3_dst_ptr_q,
  input wire logic [31:0] chan4_dst_ptr_q
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  logic rd, wr, lock, wr3, step3;
  // request decode; a refused pci write must not count as a write
  assign rd = reg_req.valid && !reg_req.write;
  assign wr = reg_req.valid && reg_req.write;
  assign lock = reg_req.from_pci && protected_mode;
  assign wr3 = wr && !lock && reg_req.offset == 8'hd8;
  assign step3 = chan3_dst_step.done && chan3_enable && !wr3;
  hide_read_a: assert property (rd && lock && reg_req.offset inside {8'hb8, 8'hbc, 8'hd8}
    |=> rd_valid_q && rd_data_q == 32'h0) else $error("locked register visible to pci");
  src_lock_a: assert property (wr && lock && reg_req.offset == 8'hd0 |=> $stable(chan3_src_ptr_q))
    else $error("locked source pointer written");
  ch4_open_a: assert property (wr && reg_req.from_pci && reg_req.offset == 8'hdc
    |=> chan4_dst_ptr_q == $past(reg_req.wdata)) else $error("channel four pointer write lost");
  shadow_read_a: assert property (rd && reg_req.offset == 8'hc0 && $stable(base_window0)
    |=> rd_data_q == $past(base_window0)) else $error("base shadow mismatch");
  dst_adv_a: assert property (step3 && !chan3_dst_step.jump && !chan3_dst_step.skip
    |=> chan3_dst_ptr_q == $past(chan3_dst_ptr_q) + dma_regs_pkg::DST_CMD_STEP) else $error("bad advance");
  dst_skip_a: assert property (step3 && !chan3_dst_step.jump && chan3_dst_step.skip
    |=> chan3_dst_ptr_q == $past(chan3_dst_ptr_q) + dma_regs_pkg::DST_SKIP_STEP) else $error("bad skip");
  dst_jump_a: assert property (step3 && chan3_dst_step.jump
    |=> chan3_dst_ptr_q == $past(chan3_dst_step.target)) else $error("bad jump");
  dst_hold_a: assert property (!chan3_enable && !wr3 |=> $stable(chan3_dst_ptr_q))
    else $error("disabled channel pointer moved");
  sw_write_a: assert property (wr3 |=> chan3_dst_ptr_q == $past(reg_req.wdata))
    else $error("pointer write lost");
  irq_route_a: assert property (irq_pci_q |-> $past(route_to_pci))
    else $error("pci irq without route");
  cover property (step3 && chan3_dst_step.jump);
  cover property (rd && lock);
  cover property (irq_pci_q);
endmodule
bind dma_status_irq_pointer_regs dma_regs_checker chk_u (.clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req),
  .protected_mode(protected_mode), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
  .route_to_pci(route_to_pci), .irq_pci_q(irq_pci_q), .base_window0(base_window0),
  .chan3_enable(chan3_enable), .chan3_dst_step(chan3_dst_step), .chan3_src_ptr_q(chan3_src_ptr_q),
  .chan3_dst_ptr_q(chan3_dst_ptr_q), .chan4_dst_ptr_q(chan4_dst_ptr_q));

// >>> dv/reg_host_model.sv
// partner model: pci host and embedded processor issuing register accesses
`timescale 1ns/1ps
module reg_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output dma_regs_pkg::reg_req_t reg_req,
  input wire logic [31:0] rd_data_q
);
  logic [31:0] last_q;
  initial reg_req = '0;
  // one access; released lines show the inverse so stale values never pass
  task automatic acc(input logic w, input logic p, input logic [7:0] o, input logic [31:0] d);
    if (o == 8'hb8 || o == 8'hbc)
      d = d & dma_regs_pkg::STATUS_IMPL_MASK;
    reg_req = {1'b1, w, p, o, d};
    @(posedge clk_sys);
    #1;
    last_q = rd_data_q;
    reg_req = {1'b0, ~w, ~p, ~o, ~d};
    @(posedge clk_sys);
    #1;
  endtask
endmodule

// >>> dv/tb_top.sv
// self-checking testbench for the dma status, irq and pointer register bank
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, rst_b, protected_mode, route_to_pci, route_to_proc, ew_valid, c3_en, c4_en;
  logic rd_valid_q, irq_pci_q, irq_proc_q;
  logic [31:0] rd_data_q, bw0, bw1, bw2, seed, exp, v, e3, e4, sdx;
  logic [31:0] chan3_src_ptr_q, chan4_src_ptr_q, chan3_dst_ptr_q, chan4_dst_ptr_q;
  logic [31:0] pv [4];
  logic [7:0] hid [6];
  logic [15:0] w10, w11;
  logic [21:0] ev;
  dma_regs_pkg::reg_req_t reg_req;
  dma_regs_pkg::dst_step_t step;
  int errors, n_compared;
  dma_status_irq_pointer_regs #(.PTR_W(32)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req),
    .protected_mode(protected_mode), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
    .evt(dma_regs_pkg::evt_t'(ev[11:0])), .dst_abort_evt(ev[13:12]), .dst_done_evt(ev[15:14]),
    .dst_last_evt(ev[17:16]), .dst_wait_evt(ev[19:18]), .dst_overflow_evt(ev[21:20]),
    .route_to_pci(route_to_pci), .route_to_proc(route_to_proc), .irq_pci_q(irq_pci_q),
    .irq_proc_q(irq_proc_q), .base_window0(bw0), .base_window1(bw1), .base_window2(bw2),
    .eeprom_words_valid(ew_valid), .eeprom_word_10(w10), .eeprom_word_11(w11), .chan3_enable(c3_en),
    .chan4_enable(c4_en), .chan3_dst_step(step), .chan4_dst_step(step), .chan3_src_ptr_q(chan3_src_ptr_q),
    .chan4_src_ptr_q(chan4_src_ptr_q), .chan3_dst_ptr_q(chan3_dst_ptr_q), .chan4_dst_ptr_q(chan4_dst_ptr_q));
  reg_host_model host_u (.clk_sys(clk_sys), .reg_req(reg_req), .rd_data_q(rd_data_q));
  // lfsr source of every random value
  function automatic logic [31:0] rn();
    seed = {seed[30:0], ^(seed & 32'h8020_0003)};
    return seed;
  endfunction
  // status image expected from one cycle of event inputs
  function automatic logic [31:0] expst(input logic [21:0] e);
    return {2'h0, e[13], e[15], e[17], e[19], e[21], 3'h0, e[12], e[14], e[16], e[18], e[20], 3'h0,
      e[11], e[9], e[7], e[5], 4'h0, e[10], e[8], e[6], e[4], e[1], e[0]};
  endfunction
  function automatic logic [31:0] sd(input logic [15:0] lo, input logic [15:0] hi);
    return {1'b1, hi[14:0], 1'b1, lo[14:0]};
  endfunction
  // destination pointer after one step: 0 plain, 1 skip, 2 jump, 3 disabled
  function automatic logic [31:0] nxt(input int k, input logic [31:0] p, input logic [31:0] t);
    return k == 3 ? p : k == 2 ? t : p + (k == 1 ? 32'h0000_0020 : 32'h0000_0010);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic rd(input logic p, input logic [7:0] o, input logic [31:0] want);
    host_u.acc(1'b0, p, o, 32'h0);
    chk(host_u.last_q, want);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic results;
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // watchdog well beyond the roughly 170 cycles the sequence needs
  initial begin
    #(50 * 5000);
    errors++;
    results();
  end
  initial begin
    errors = 0;
    n_compared = 0;
    seed = 32'h0000_003b;
    hid = '{8'hb8, 8'hbc, 8'hcc, 8'hd0, 8'hd4, 8'hd8};
    {rst_b, protected_mode, route_to_pci, route_to_proc, c3_en, c4_en, ev, step} = '0;
    ew_valid = 1'b1;
    v = rn();
    {w11, w10} = v;
    sdx = sd(w10, w11);
    bw0 = rn();
    bw1 = rn();
    bw2 = rn();
    repeat (20) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    cyc(2);
    {w11, w10} = ~v;
    for (int i = 0; i < 6; i++)
      rd(1'b0, hid[i], i == 2 ? sdx : 32'h0);
    rd(1'b0, 8'h04, 32'h0);
    rd(1'b0, 8'hcc, sdx);
    host_u.acc(1'b1, 1'b1, 8'hc0, rn());
    rd(1'b1, 8'hc0, bw0);
    bw1 = rn();
    cyc(2);
    rd(1'b1, 8'hc4, bw1);
    for (int i = 0; i < 4; i++) begin
      pv[i] = rn();
      host_u.acc(1'b1, 1'b0, 8'(8'hd0 + 4 * i), pv[i]);
      rd(1'b0, 8'(8'hd0 + 4 * i), pv[i]);
    end
    chk(chan3_src_ptr_q, pv[0]);
    chk(chan4_src_ptr_q, pv[1]);
    exp = 32'h0;
    for (int i = 0; i < 4; i++) begin
      v = rn();
      ev = (i == 0) ? '1 : v[21:0];
      exp = exp | expst(ev);
      cyc(1);
      ev = '0;
      cyc(3);
      rd(1'b0, 8'hb8, exp);
      v = rn();
      host_u.acc(1'b1, 1'b0, 8'hb8, v);
      exp = exp & ~v;
      rd(1'b0, 8'hb8, exp);
    end
    host_u.acc(1'b1, 1'b0, 8'hb8, 32'hffff_ffff);
    host_u.acc(1'b1, 1'b0, 8'hbc, 32'h0000_0010);
    rd(1'b0, 8'hbc, 32'h0000_0010);
    for (int i = 0; i < 4; i++) begin
      {route_to_pci, route_to_proc} = 2'(i);
      ev = 22'h000100;
      cyc(1);
      ev = 22'h000010;
      cyc(2);
      chk({30'h0, irq_pci_q, irq_proc_q}, 32'(i));
      ev = '0;
      host_u.acc(1'b1, 1'b0, 8'hb8, 32'h0000_0010);
      chk({30'h0, irq_pci_q, irq_proc_q}, 32'h0);
    end
    // pointers are loaded only while both channels are disabled
    e3 = rn();
    e4 = rn();
    host_u.acc(1'b1, 1'b0, 8'hd8, e3);
    host_u.acc(1'b1, 1'b0, 8'hdc, e4);
    for (int k = 0; k < 4; k++) begin
      c3_en = (k != 3);
      c4_en = (k != 3);
      step = {1'b1, k == 2, k == 1, rn()};
      e3 = nxt(k, e3, step.target);
      e4 = nxt(k, e4, step.target);
      cyc(1);
      step.done = 1'b0;
      chk(chan3_dst_ptr_q, e3);
      chk(chan4_dst_ptr_q, e4);
      cyc(1);
    end
    c3_en = 1'b0;
    c4_en = 1'b0;
    protected_mode = 1'b1;
    for (int i = 0; i < 6; i++)
      rd(1'b1, hid[i], 32'h0);
    host_u.acc(1'b1, 1'b1, 8'hd0, rn());
    rd(1'b0, 8'hd0, pv[0]);
    host_u.acc(1'b1, 1'b1, 8'hbc, 32'hffff_ffff);
    rd(1'b0, 8'hbc, 32'h0000_0010);
    host_u.acc(1'b1, 1'b1, 8'hb8, 32'hffff_ffff);
    rd(1'b0, 8'hb8, 32'h0000_0004);
    rd(1'b0, 8'hcc, sdx);
    rd(1'b1, 8'hc8, bw2);
    v = rn();
    host_u.acc(1'b1, 1'b1, 8'hdc, v);
    rd(1'b1, 8'hdc, v);
    results();
  end
endmodule
